//--- fbd_decoder.sv
// Purpose: instruction decode and array address extension of a serial flash
// Assumes: host drives cs_n, sck and io lines; array logic pulses fetch_next per byte
// Notes: link front end runs on sck; decode results and addresses live on clock
`timescale 1ns/10ps

module fbd_decoder import fbd_pkg::*; #(
  parameter int BANKS = `FBD_BANK_COUNT
) (
  input wire logic clock, // system clock, 25 MHz
  input wire logic resetn, // synchronous reset, active low
  input wire logic sck, // link clock from the host
  input wire logic cs_n, // chip select pin, active low
  input wire logic [3:0] io_in, // io pin levels
  output logic [3:0] io_out, // io pin drive values
  output logic [3:0] io_oe, // io pin drive enables
  input wire logic fetch_next, // one-cycle pulse: array consumed one streamed byte
  output logic cmd_valid, // one-cycle pulse: instruction decoded
  output fbd_class_t cmd_class, // decoded instruction class
  output logic addr_valid, // one-cycle pulse: array_addr holds a new start address
  output logic [31:0] array_addr, // current array byte address
  output logic [7:0] bank_select, // bank-select register
  output logic wide_address_flag, // four-byte address mode for legacy instructions
  output logic frame_active // chip select seen low
);
  localparam logic [31:0] ARRAY_LAST = 32'(BANKS) * `FBD_BANK_BYTES - 32'h0000_0001;

  fbd_top_st_t s;
  fbd_top_st_t next_s;
  fbd_frame_t frame;
  fbd_decode_t dec;
  logic link_op_seen;
  logic link_tail_seen;
  logic so_out;
  logic so_oe;
  logic [7:0] bank_sync;
  logic [2:0] ctl_sync;
  logic cs_s;
  logic op_s;
  logic tail_s;
  logic op_rise;
  logic tail_rise;

  function automatic logic is_stream(input fbd_class_t c);
    case (c)
      CL_NORMAL_READ, CL_QUICK_READ, CL_DUAL_OUT, CL_QUAD_OUT, CL_DUAL_IO, CL_QUAD_IO,
      CL_DDR_QUICK, CL_DDR_DUAL_IO, CL_DDR_QUAD_IO: is_stream = 1'b1;
      default: is_stream = 1'b0;
    endcase
  endfunction

  fbd_link_rx u_link (
    .sck(sck),
    .cs_n(cs_n),
    .io_in(io_in),
    .bank_sync(bank_sync),
    .frame(frame),
    .op_seen(link_op_seen),
    .tail_seen(link_tail_seen),
    .so_out(so_out),
    .so_oe(so_oe)
  );

  // the bank value is quasi-static while a frame runs, so per-bit syncing is safe
  fbd_sync #(.W(8), .INIT(8'h00)) u_bank_to_link (
    .clock(sck),
    .resetn(1'b1),
    .d(s.bank),
    .q(bank_sync)
  );

  fbd_sync #(.W(3), .INIT(3'b100)) u_link_to_sys (
    .clock(clock),
    .resetn(resetn),
    .d({cs_n, link_op_seen, link_tail_seen}),
    .q(ctl_sync)
  );

  assign cs_s = ctl_sync[2];
  assign op_s = ctl_sync[1];
  assign tail_s = ctl_sync[0];
  // frame payload is stable well before its flag arrives through the synchroniser
  assign op_rise = op_s & ~s.op_seen_d;
  assign tail_rise = tail_s & ~s.tail_seen_d;

  always_comb begin
    next_s = s;
    dec = fbd_decode(frame.opcode);
    next_s.cmd_valid = 1'b0;
    next_s.addr_valid = 1'b0;
    next_s.op_seen_d = op_s;
    next_s.tail_seen_d = tail_s;
    next_s.frame_active = ~cs_s;
    if (op_rise) begin
      next_s.cmd_valid = 1'b1;
      next_s.cmd_class = dec.cls;
    end
    if (tail_rise) begin
      if (dec.alen != AL_NONE) begin
        next_s.addr_valid = 1'b1;
        next_s.reading = is_stream(dec.cls);
        if (frame.wide || dec.alen != AL_LEGACY) begin
          next_s.array_addr = frame.addr;
        end else begin
          // reads, programs and erases all take the same bank prefix
          next_s.array_addr = 32'({s.bank[`FBD_BANK_MSB:`FBD_BANK_LSB],
            frame.addr[23:0]});
        end
      end else if (dec.data_in) begin
        next_s.bank = frame.data & `FBD_BANK_WR_MASK;
      end
    end else if (fetch_next && s.reading) begin
      // the bank register is left alone while streaming across banks
      next_s.array_addr = (s.array_addr == ARRAY_LAST) ? 32'h0000_0000 :
        s.array_addr + 32'h0000_0001;
    end
    if (cs_s) begin
      next_s.reading = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s.bank <= `FBD_BANK_RESET;
      s.op_seen_d <= 1'b0;
      s.tail_seen_d <= 1'b0;
      s.cmd_valid <= 1'b0;
      s.cmd_class <= CL_NONE;
      s.addr_valid <= 1'b0;
      s.array_addr <= 32'h0000_0000;
      s.reading <= 1'b0;
      s.frame_active <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign cmd_valid = s.cmd_valid;
  assign cmd_class = s.cmd_class;
  assign addr_valid = s.addr_valid;
  assign array_addr = s.array_addr;
  assign bank_select = s.bank;
  assign wide_address_flag = s.bank[`FBD_WIDE_BIT];
  assign frame_active = s.frame_active;
  assign io_out = {2'b00, so_out, 1'b0};
  assign io_oe = {2'b00, so_oe, 1'b0};

  property p_bank_reset;
    @(posedge clock) !resetn |=> bank_select[`FBD_BANK_MSB:`FBD_BANK_LSB] == 2'b00;
  endproperty
  a_bank_reset: assert property (p_bank_reset) else $error("bank not zero after reset");

  property p_wide_reset;
    @(posedge clock) !resetn ##1 !resetn |=> !wide_address_flag;
  endproperty
  a_wide_reset: assert property (p_wide_reset)
    else $error("wide flag set after reset");

  property p_legacy_prefix;
    @(posedge clock) disable iff (!resetn)
      tail_rise && dec.alen == AL_LEGACY && !frame.wide |=> addr_valid &&
      array_addr[23:0] == $past(frame.addr[23:0]) &&
      array_addr[31:24] == {6'h00, $past(s.bank[`FBD_BANK_MSB:`FBD_BANK_LSB])};
  endproperty
  a_legacy_prefix: assert property (p_legacy_prefix)
    else $error("bank prefix wrong");

  property p_bank_map;
    @(posedge clock) disable iff (!resetn)
      tail_rise && dec.alen == AL_LEGACY && !frame.wide && s.bank[1:0] == 2'b11
      |=> array_addr[31:24] == 8'h03;
  endproperty
  a_bank_map: assert property (p_bank_map) else $error("bank 3 not at 03000000");

  property p_wide_addr;
    @(posedge clock) disable iff (!resetn)
      tail_rise && dec.alen == AL_LEGACY && frame.wide |=> array_addr == $past(frame.addr);
  endproperty
  a_wide_addr: assert property (p_wide_addr) else $error("four-byte address altered");

  property p_corr_four;
    @(posedge clock) disable iff (!resetn)
      tail_rise && dec.cls == CL_CORR_STATUS |-> frame.wide ##1 addr_valid;
  endproperty
  a_corr_four: assert property (p_corr_four) else $error("ecc status not four bytes");

  property p_stream;
    @(posedge clock) disable iff (!resetn)
      s.reading && fetch_next && !tail_rise && !cs_s && s.array_addr != ARRAY_LAST
      |=> array_addr == $past(array_addr) + 32'h0000_0001;
  endproperty
  a_stream: assert property (p_stream) else $error("stream address did not step");

  property p_bank_hold;
    @(posedge clock) disable iff (!resetn)
      s.reading && fetch_next && !tail_rise |=> $stable(bank_select);
  endproperty
  a_bank_hold: assert property (p_bank_hold)
    else $error("bank changed while streaming");

  property p_bank_store;
    @(posedge clock) disable iff (!resetn)
      tail_rise && dec.cls == CL_BANK_STORE
      |=> bank_select == ($past(frame.data) & `FBD_BANK_WR_MASK) && !addr_valid;
  endproperty
  a_bank_store: assert property (p_bank_store) else $error("bank store lost");

  property p_decode_read;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_NORMAL_READ |=> cmd_valid && cmd_class == CL_NORMAL_READ;
  endproperty
  a_decode_read: assert property (p_decode_read) else $error("read not decoded");

  property p_decode_wipe;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_SECTOR_WIPE
      |=> cmd_class == CL_SECTOR_WIPE ##1 !cmd_valid;
  endproperty
  a_decode_wipe: assert property (p_decode_wipe) else $error("wipe not decoded");

  // one code per instruction group
  property p_decode_dual;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_DUAL_OUT |=> cmd_class == CL_DUAL_OUT;
  endproperty
  a_decode_dual: assert property (p_decode_dual) else $error("dual out not decoded");

  property p_decode_quad;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_QUAD_IO |=> cmd_class == CL_QUAD_IO;
  endproperty
  a_decode_quad: assert property (p_decode_quad) else $error("quad io not decoded");

  property p_decode_ddr;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_DDR_QUAD_IO |=> cmd_class == CL_DDR_QUAD_IO;
  endproperty
  a_decode_ddr: assert property (p_decode_ddr) else $error("ddr quad not decoded");

  property p_decode_latch;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_WLATCH_SET |=> cmd_class == CL_WLATCH_SET;
  endproperty
  a_decode_latch: assert property (p_decode_latch) else $error("latch set lost");

  property p_decode_clear;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_FAIL_CLR |=> cmd_class == CL_FAIL_CLR;
  endproperty
  a_decode_clear: assert property (p_decode_clear) else $error("fail clear lost");

  property p_decode_learn;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_V_LEARN |=> cmd_class == CL_V_LEARN;
  endproperty
  a_decode_learn: assert property (p_decode_learn) else $error("learn store lost");

  property p_decode_ident;
    @(posedge clock) disable iff (!resetn)
      op_rise && frame.opcode == `FBD_OP_JEDEC_ID |=> cmd_class == CL_JEDEC_ID;
  endproperty
  a_decode_ident: assert property (p_decode_ident) else $error("ident fetch lost");

  // the legacy access code acts as a bank store with one data byte
  property p_legacy_store;
    @(posedge clock) disable iff (!resetn)
      tail_rise && dec.cls == CL_LEGACY_BANK
      |=> bank_select == ($past(frame.data) & `FBD_BANK_WR_MASK);
  endproperty
  a_legacy_store: assert property (p_legacy_store) else $error("legacy store lost");

  property p_wide_store;
    @(posedge clock) disable iff (!resetn)
      tail_rise && dec.data_in |=> wide_address_flag == $past(frame.data[`FBD_WIDE_BIT]);
  endproperty
  a_wide_store: assert property (p_wide_store) else $error("wide flag store lost");

  c_legacy_bank1: cover property (@(posedge clock) disable iff (!resetn)
    addr_valid && array_addr[31:24] == 8'h01);
  c_wide_read: cover property (@(posedge clock) disable iff (!resetn)
    tail_rise && frame.wide && dec.alen == AL_LEGACY);
  c_cross_bank: cover property (@(posedge clock) disable iff (!resetn)
    s.reading && fetch_next && s.array_addr[23:0] == 24'hFF_FFFF);
  c_bank_store: cover property (@(posedge clock) disable iff (!resetn)
    tail_rise && dec.cls == CL_BANK_STORE);
  c_dual_lane: cover property (@(posedge clock) disable iff (!resetn)
    tail_rise && dec.lanes == 3'd2);
endmodule

//--- fbd_decoder_bench.sv
// Purpose: self-checking bench of the instruction decoder and bank extension
// Assumes: fbd_host plays the link master
// Notes: expectations come from the bank map, never from dut outputs
`timescale 1ns/10ps

module fbd_decoder_bench;
  import fbd_pkg::*;
  localparam logic [7:0] OPS [28] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h0D,
    8'hBD, 8'hED, 8'h02, 8'h32, 8'hD8, 8'h01, 8'h04, 8'h06, 8'h05, 8'h07, 8'h30, 8'h16,
    8'h17, 8'hB9, 8'h18, 8'h41, 8'h43, 8'h4A, 8'h90, 8'h9F, 8'h5A};
  localparam logic [7:0] LEG [4] = '{8'h03, 8'h02, 8'hD8, 8'hEB};
  logic clock, resetn, fetch_next, cmd_valid, addr_valid, wide_address_flag, frame_active;
  logic sck, cs_n;
  logic [3:0] hio, io_out, io_oe;
  logic [31:0] array_addr, r, seed;
  logic [7:0] bank_select;
  fbd_class_t cmd_class;
  int mismatches, tests_run, c;
  int ncmd = 0;
  int nadr = 0;
  wire logic [3:0] pins = {hio[3:2], io_oe[1] ? io_out[1] : hio[1], hio[0]};

  fbd_host host (.sck(sck), .cs_n(cs_n), .io(hio), .so(io_out[1]), .so_oe(io_oe[1]));
  fbd_decoder dut (.clock(clock), .resetn(resetn), .sck(sck), .cs_n(cs_n), .io_in(pins),
    .io_out(io_out), .io_oe(io_oe), .fetch_next(fetch_next), .cmd_valid(cmd_valid),
    .cmd_class(cmd_class), .addr_valid(addr_valid), .array_addr(array_addr),
    .bank_select(bank_select), .wide_address_flag(wide_address_flag),
    .frame_active(frame_active));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (cmd_valid === 1'b1) ncmd <= ncmd + 1;
    if (addr_valid === 1'b1) nadr <= nadr + 1;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // bank bits above the 24 received address bits
  function automatic logic [31:0] exp_addr(input logic [7:0] bank, input logic [31:0] a);
    return {6'h00, bank[1:0], a[23:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic set_bank(input logic [7:0] v);
    host.shift({24'h0, 8'h17}, 8, 1);
    host.shift({24'h0, v}, 8, 1);
    host.stop();
    check(bank_select, v & 8'h83);
    check(wide_address_flag, v[7]);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    seed = 32'h5628_9d9e;
    resetn = 1'b0;
    fetch_next = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    check(bank_select, 32'h0000_0000);
    check(wide_address_flag, 32'h0000_0000);
    // every listed code, then one unknown code
    for (int i = 0; i < 29; i++) begin
      c = ncmd;
      host.shift(i < 28 ? OPS[i] : 8'hFF, 8, 1);
      host.stop();
      check(cmd_class, i < 28 ? i + 1 : 0);
      check(ncmd - c, 1);
    end
    // banks 0 to 3 with a read, program, erase and quad io read, one per bank
    for (int b = 0; b < 4; b++) begin
      r = rnd();
      set_bank({1'b0, r[30:26], 2'(b)});
      c = nadr;
      host.shift({24'h0, LEG[b]}, 8, 1);
      host.shift(r, 24, LEG[b] == 8'hEB ? 4 : 1);
      host.stop();
      check(array_addr, exp_addr(8'(b), r));
      check(nadr - c, 1);
    end
    // dual-lane legacy address in bank 2
    set_bank(8'h02);
    r = rnd();
    host.shift(32'hBD, 8, 1);
    host.shift(r, 24, 2);
    host.stop();
    check(array_addr, exp_addr(8'h02, r));
    set_bank(8'h81);
    r = rnd();
    c = nadr;
    host.shift(32'h03, 8, 1);
    host.shift(r, 24, 1);
    host.stop();
    check(nadr - c, 0);
    host.shift(32'h03, 8, 1);
    host.shift(r, 32, 1);
    host.stop();
    check(array_addr, r);
    set_bank(8'h00);
    host.shift(32'h18, 8, 1);
    host.shift(~r, 32, 1);
    host.stop();
    check(array_addr, ~r);
    r = rnd();
    set_bank(r[7:0]);
    host.shift(32'h16, 8, 1);
    host.shift(32'h0, 8, 1);
    host.stop();
    check(host.got, r[7:0] & 8'h83);
    // stream across the bank edge with chip select held low
    set_bank(8'h01);
    host.shift(32'h03, 8, 1);
    host.shift(32'h00FF_FFFE, 24, 1);
    repeat (8) @(posedge clock);
    check(frame_active, 32'h0000_0001);
    for (int k = 1; k < 4; k++) begin
      fetch_next <= 1'b1;
      @(posedge clock);
      fetch_next <= 1'b0;
      @(posedge clock);
      check(array_addr, 32'h01FF_FFFE + k);
      check(bank_select, 32'h0000_0001);
    end
    host.stop();
    // legacy access code stores the bank, then a hardware reset clears it
    host.shift(32'hB9, 8, 1);
    host.shift(32'hFF, 8, 1);
    host.stop();
    check(bank_select, 32'h0000_0083);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    check(bank_select, 32'h0000_0000);
    check(wide_address_flag, 32'h0000_0000);
    end_sim();
  end
endmodule

//--- fbd_defs.svh
// Purpose: constants of the flash instruction decoder and bank address extension
// Assumes: included by fbd_pkg only; the design modules use its macros without including it
// Notes: opcodes are the eight-bit instruction values seen on the serial input
`ifndef FBD_DEFS_SVH
`define FBD_DEFS_SVH

// legacy array instructions (three or four address bytes)
`define FBD_OP_NORMAL_READ 8'h03
`define FBD_OP_QUICK_READ 8'h0B
`define FBD_OP_DUAL_OUT 8'h3B
`define FBD_OP_QUAD_OUT 8'h6B
`define FBD_OP_DUAL_IO 8'hBB
`define FBD_OP_QUAD_IO 8'hEB
`define FBD_OP_DDR_QUICK 8'h0D
`define FBD_OP_DDR_DUAL_IO 8'hBD
`define FBD_OP_DDR_QUAD_IO 8'hED
`define FBD_OP_PAGE_WRITE 8'h02
`define FBD_OP_QUAD_PAGE 8'h32
`define FBD_OP_SECTOR_WIPE 8'hD8
// register access and identification
`define FBD_OP_STATUS_CONFIG_STORE 8'h01
`define FBD_OP_WLATCH_CLR 8'h04
`define FBD_OP_WLATCH_SET 8'h06
`define FBD_OP_STATUS_ONE 8'h05
`define FBD_OP_STATUS_TWO 8'h07
`define FBD_OP_FAIL_CLR 8'h30
`define FBD_OP_BANK_FETCH 8'h16
`define FBD_OP_BANK_STORE 8'h17
`define FBD_OP_LEGACY_BANK 8'hB9
`define FBD_OP_CORR_STATUS 8'h18
`define FBD_OP_LEARN_FETCH 8'h41
`define FBD_OP_NV_LEARN 8'h43
`define FBD_OP_V_LEARN 8'h4A
`define FBD_OP_MAKER_SIG 8'h90
`define FBD_OP_JEDEC_ID 8'h9F
`define FBD_OP_PARAM_TABLE 8'h5A

// bank-select register layout
`define FBD_BANK_RESET 8'h00
`define FBD_BANK_WR_MASK 8'h83
`define FBD_WIDE_BIT 7
`define FBD_BANK_MSB 1
`define FBD_BANK_LSB 0
`define FBD_BANK_BYTES 32'h0100_0000
`define FBD_BANK_COUNT 4

// address field lengths in bits, and the index of the last bit of a byte
`define FBD_ADDR_BITS_NARROW 6'd24
`define FBD_ADDR_BITS_WIDE 6'd32
`define FBD_BYTE_LAST 6'd7

`endif

//--- fbd_host.sv
// Purpose: host side model driving chip select, link clock and io lines
// Assumes: mode 0 link, 125 ns link clock that stands low outside frames
// Notes: released io lines show the inverse of their last value
`timescale 1ns/10ps

module fbd_host (
  output logic sck, // link clock
  output logic cs_n, // chip select, active low
  output logic [3:0] io, // io lines toward the device
  input wire logic so, // serial output of the device
  input wire logic so_oe // device drives so
);
  logic [7:0] got = 8'h00;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io = 4'h0;
  end
  // an undriven line reads as the inverse, so a stale bit never looks valid
  always @(posedge sck) got <= {got[6:0], so_oe ? so : ~got[0]};
  // msb first, w bits per rising edge; instructions go with w = 1
  task automatic shift(input logic [31:0] v, input int n, input int w);
    if (cs_n) begin
      cs_n = 1'b0;
      #37;
    end
    for (int i = n - w; i >= 0; i -= w) begin
      io = 4'((v >> i) & ((1 << w) - 1));
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
  endtask
  // gap covers the 3-4 clock answer and the 160 ns deselect time
  task automatic stop();
    #30 cs_n = 1'b1;
    io = ~io;
    #300;
  endtask
endmodule

//--- fbd_link_rx.sv
// Purpose: serial-clock front end: instruction, address and data byte capture
// Assumes: mode 0 link; chip select high resets the frame state asynchronously
// Notes: payload is not reset so it stays readable after the frame has ended
`timescale 1ns/10ps

module fbd_link_rx import fbd_pkg::*; (
  input wire logic sck, // link clock from the host
  input wire logic cs_n, // chip select, active low
  input wire logic [3:0] io_in, // serial data lines, io_in[0] is the single input
  input wire logic [7:0] bank_sync, // bank register seen in the link domain
  output fbd_frame_t frame, // captured instruction, address and data
  output logic op_seen, // level: instruction byte complete in this frame
  output logic tail_seen, // level: address or data byte complete in this frame
  output logic so_out, // serial output bit
  output logic so_oe // serial output enable
);
  fbd_link_st_t st;
  fbd_link_st_t next_st;
  fbd_link_pl_t pl;
  fbd_link_pl_t next_pl;
  fbd_decode_t dec_new;
  fbd_decode_t dec_held;
  logic [7:0] op_full;
  logic so_q;

  always_comb begin
    next_st = st;
    next_pl = pl;
    op_full = {pl.f.opcode[6:0], io_in[0]};
    dec_new = fbd_decode(op_full);
    dec_held = fbd_decode(pl.f.opcode);
    case (st.phase)
      PH_OPCODE: begin
        next_pl.f.opcode = op_full;
        next_st.bits = st.bits + 6'd1;
        if (st.bits == `FBD_BYTE_LAST) begin
          next_st.bits = 6'd0;
          next_st.op_seen = 1'b1;
          next_pl.f.addr = 32'h0000_0000;
          next_pl.f.wide = (dec_new.alen == AL_FOUR) ||
            (dec_new.alen == AL_LEGACY && bank_sync[`FBD_WIDE_BIT]);
          if (dec_new.alen != AL_NONE) begin
            next_st.phase = PH_ADDRESS;
          end else if (dec_new.data_in) begin
            next_st.phase = PH_DATA;
          end else if (dec_new.reg_out) begin
            next_st.phase = PH_OUT;
            next_pl.shift = bank_sync;
          end else begin
            next_st.phase = PH_IDLE;
          end
        end
      end
      PH_ADDRESS: begin
        case (dec_held.lanes)
          3'd4: next_pl.f.addr = {pl.f.addr[27:0], io_in};
          3'd2: next_pl.f.addr = {pl.f.addr[29:0], io_in[1:0]};
          default: next_pl.f.addr = {pl.f.addr[30:0], io_in[0]};
        endcase
        next_st.bits = st.bits + 6'(dec_held.lanes);
        if (next_st.bits == (pl.f.wide ? `FBD_ADDR_BITS_WIDE : `FBD_ADDR_BITS_NARROW)) begin
          next_st.tail_seen = 1'b1;
          next_st.phase = PH_IDLE;
        end
      end
      PH_DATA: begin
        next_pl.f.data = {pl.f.data[6:0], io_in[0]};
        next_st.bits = st.bits + 6'd1;
        if (st.bits == `FBD_BYTE_LAST) begin
          next_st.tail_seen = 1'b1;
          next_st.phase = PH_IDLE;
        end
      end
      PH_OUT: next_pl.shift = {pl.shift[6:0], 1'b0};
      default: next_st.bits = st.bits;
    endcase
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      st.phase <= PH_OPCODE;
      st.bits <= 6'd0;
      st.op_seen <= 1'b0;
      st.tail_seen <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // the link clock stops between frames, so the payload simply holds
  always_ff @(posedge sck) begin
    pl <= next_pl;
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_q <= 1'b0;
    end else begin
      so_q <= pl.shift[7];
    end
  end

  assign frame = pl.f;
  assign op_seen = st.op_seen;
  assign tail_seen = st.tail_seen;
  assign so_out = so_q;
  assign so_oe = (st.phase == PH_OUT);
endmodule

//--- fbd_pkg.sv
// Purpose: types and the shared instruction decode of the bank address decoder
// Assumes: fbd_defs.svh holds every opcode and bank constant; lane counts are literals in fbd_decode
// Notes: the decode function is used in both clock domains
`include "fbd_defs.svh"

package fbd_pkg;

  typedef enum logic [4:0] {
    CL_NONE, CL_NORMAL_READ, CL_QUICK_READ, CL_DUAL_OUT, CL_QUAD_OUT, CL_DUAL_IO,
    CL_QUAD_IO, CL_DDR_QUICK, CL_DDR_DUAL_IO, CL_DDR_QUAD_IO, CL_PAGE_WRITE,
    CL_QUAD_PAGE, CL_SECTOR_WIPE, CL_STATUS_CONFIG_STORE, CL_WLATCH_CLR, CL_WLATCH_SET,
    CL_STATUS_ONE, CL_STATUS_TWO, CL_FAIL_CLR, CL_BANK_FETCH, CL_BANK_STORE,
    CL_LEGACY_BANK, CL_CORR_STATUS, CL_LEARN_FETCH, CL_NV_LEARN, CL_V_LEARN,
    CL_MAKER_SIG, CL_JEDEC_ID, CL_PARAM_TABLE
  } fbd_class_t;

  typedef enum logic [1:0] {AL_NONE, AL_LEGACY, AL_THREE, AL_FOUR} fbd_alen_t;

  typedef enum {PH_OPCODE, PH_ADDRESS, PH_DATA, PH_OUT, PH_IDLE} fbd_phase_t;

  typedef struct packed {
    fbd_class_t cls;
    fbd_alen_t alen;
    logic [2:0] lanes;
    logic data_in;
    logic reg_out;
  } fbd_decode_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [7:0] data;
    logic wide;
  } fbd_frame_t;

  typedef struct packed {
    fbd_phase_t phase;
    logic [5:0] bits;
    logic op_seen;
    logic tail_seen;
  } fbd_link_st_t;

  typedef struct packed {
    fbd_frame_t f;
    logic [7:0] shift;
  } fbd_link_pl_t;

  typedef struct packed {
    logic [7:0] bank;
    logic op_seen_d;
    logic tail_seen_d;
    logic cmd_valid;
    fbd_class_t cmd_class;
    logic addr_valid;
    logic [31:0] array_addr;
    logic reading;
    logic frame_active;
  } fbd_top_st_t;

  function automatic fbd_decode_t fbd_decode(input logic [7:0] op);
    fbd_decode_t d;
    d.cls = CL_NONE;
    d.alen = AL_NONE;
    d.lanes = 3'd1;
    d.data_in = 1'b0;
    d.reg_out = 1'b0;
    case (op)
      `FBD_OP_NORMAL_READ: begin d.cls = CL_NORMAL_READ; d.alen = AL_LEGACY; end
      `FBD_OP_QUICK_READ: begin d.cls = CL_QUICK_READ; d.alen = AL_LEGACY; end
      `FBD_OP_DUAL_OUT: begin d.cls = CL_DUAL_OUT; d.alen = AL_LEGACY; end
      `FBD_OP_QUAD_OUT: begin d.cls = CL_QUAD_OUT; d.alen = AL_LEGACY; end
      `FBD_OP_DUAL_IO: begin d.cls = CL_DUAL_IO; d.alen = AL_LEGACY; d.lanes = 3'd2; end
      `FBD_OP_QUAD_IO: begin d.cls = CL_QUAD_IO; d.alen = AL_LEGACY; d.lanes = 3'd4; end
      `FBD_OP_DDR_QUICK: begin d.cls = CL_DDR_QUICK; d.alen = AL_LEGACY; end
      `FBD_OP_DDR_DUAL_IO: begin
        d.cls = CL_DDR_DUAL_IO; d.alen = AL_LEGACY; d.lanes = 3'd2;
      end
      `FBD_OP_DDR_QUAD_IO: begin
        d.cls = CL_DDR_QUAD_IO; d.alen = AL_LEGACY; d.lanes = 3'd4;
      end
      `FBD_OP_PAGE_WRITE: begin d.cls = CL_PAGE_WRITE; d.alen = AL_LEGACY; end
      `FBD_OP_QUAD_PAGE: begin d.cls = CL_QUAD_PAGE; d.alen = AL_LEGACY; end
      `FBD_OP_SECTOR_WIPE: begin d.cls = CL_SECTOR_WIPE; d.alen = AL_LEGACY; end
      `FBD_OP_STATUS_CONFIG_STORE: d.cls = CL_STATUS_CONFIG_STORE;
      `FBD_OP_WLATCH_CLR: d.cls = CL_WLATCH_CLR;
      `FBD_OP_WLATCH_SET: d.cls = CL_WLATCH_SET;
      `FBD_OP_STATUS_ONE: d.cls = CL_STATUS_ONE;
      `FBD_OP_STATUS_TWO: d.cls = CL_STATUS_TWO;
      `FBD_OP_FAIL_CLR: d.cls = CL_FAIL_CLR;
      `FBD_OP_BANK_FETCH: begin d.cls = CL_BANK_FETCH; d.reg_out = 1'b1; end
      `FBD_OP_BANK_STORE: begin d.cls = CL_BANK_STORE; d.data_in = 1'b1; end
      `FBD_OP_LEGACY_BANK: begin d.cls = CL_LEGACY_BANK; d.data_in = 1'b1; end
      `FBD_OP_CORR_STATUS: begin d.cls = CL_CORR_STATUS; d.alen = AL_FOUR; end
      `FBD_OP_LEARN_FETCH: d.cls = CL_LEARN_FETCH;
      `FBD_OP_NV_LEARN: d.cls = CL_NV_LEARN;
      `FBD_OP_V_LEARN: d.cls = CL_V_LEARN;
      `FBD_OP_MAKER_SIG: begin d.cls = CL_MAKER_SIG; d.alen = AL_THREE; end
      `FBD_OP_JEDEC_ID: d.cls = CL_JEDEC_ID;
      `FBD_OP_PARAM_TABLE: begin d.cls = CL_PARAM_TABLE; d.alen = AL_THREE; end
      default: d.cls = CL_NONE;
    endcase
    return d;
  endfunction

endpackage

//--- fbd_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: d is a level from another clock domain or a pin
// Notes: only the second stage is visible at q
`timescale 1ns/10ps

module fbd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock, // destination clock
  input wire logic resetn, // synchronous, active low
  input wire logic [W-1:0] d, // asynchronous level
  output logic [W-1:0] q // synchronised level
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } fbd_sync_st_t;

  fbd_sync_st_t s;
  fbd_sync_st_t next_s;

  always_comb begin
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s.meta <= INIT;
      s.stable <= INIT;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;
endmodule
